// File: logic/fifo_status_irq_timer_pkg.sv
// Constants for the buffer, interrupt and timer unit.
// Assumes a 32-bit AXI4-Lite bus, one register per aligned word.
package fifo_status_irq_timer_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_FIFO_DATA = 6'h00;
  localparam logic [5:0] OFS_FILL = 6'h04;
  localparam logic [5:0] OFS_THRESH = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0C;
  localparam logic [5:0] OFS_IRQ_EN = 6'h10;
  localparam logic [5:0] OFS_IRQ_FLAG = 6'h14;
  localparam logic [5:0] OFS_TMODE = 6'h18;
  localparam logic [5:0] OFS_RELOAD = 6'h1C;
  localparam logic [5:0] OFS_COUNT = 6'h20;
  localparam logic [5:0] OFS_CONTROL = 6'h24;
  localparam logic [5:0] OFS_COMMAND = 6'h28;
  localparam logic [5:0] OFS_FAULT = 6'h2C;
  localparam int REG_COUNT = 12;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLUSH_BIT = 7;
  localparam int FLAG_SET_BIT = 31;
  localparam int ST_LOW = 0;
  localparam int ST_HIGH = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_PENDING = 3;
  localparam int FL_TIMER = 0;
  localparam int FL_TX = 1;
  localparam int FL_RX = 2;
  localparam int FL_CMD = 3;
  localparam int FL_HIGH = 4;
  localparam int FL_LOW = 5;
  localparam int FL_FAULT = 6;
  localparam int FL_CSUM = 7;
  localparam int TM_AUTO = 0;
  localparam int TM_RELOAD = 1;
  localparam int TM_EVEN = 2;
  localparam int TM_PRE_LSB = 8;
  localparam int CTL_KICK = 0;
  localparam int CTL_HALT = 1;
  localparam int CMD_SLEEP = 4;
  localparam int FAULT_OVF = 4;
  // ----------------------------------------
  // Codes and counts
  // ----------------------------------------
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_KEEP = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SLEEP_EXIT_CLKS = 1024;
  localparam logic [31:0] TIMER_CLK_HZ = 32'h00CE_E8C0;
endpackage : fifo_status_irq_timer_pkg

// File: logic/fifo_status_irq_timer.sv
// Buffer, interrupt flag and two-stage timer unit with an AXI4-Lite slave.
// Assumes the sequencer, transmitter, receiver and checksum logic share aclk.
//
// Summary of operation
// [R1] Flush write resets both pointers, zeroes fill count and clears overflow.
// [R2] Fill count of stored bytes is readable as a seven-bit field.
// [R3] Overflow stays set until a flush write; nothing else clears it.
// [R4] High warning holds while free space is at or below the threshold.
// [R5] Low warning holds while fill count is at or below the threshold.
// [R6] Rising warnings raise the interrupt pin when their enables are set.
// [R7] Any enabled event sets the pending status bit and drives the pin.
// [R8] Timer flag sets when the counter steps from one to zero.
// [R9] Transmit-done and receive-done flags follow frame end events.
// [R10] Checksum-done flag sets when checksum ready rises.
// [R11] Command-done flag sets when a running command returns to idle.
// [R12] Warning flags set when their warning bits rise.
// [R13] Fault flag sets while any fault status bit is one.
// [R14] Timer runs through a programmable 12-bit prescaler stage.
// [R15] Second stage reloads a 16-bit value; its count is readable.
// [R16] At zero the timer flags, then halts or reloads by configuration.
// [R17] Host may both set and clear the timer flag by writing.
// [R18] Kick starts, halt stops, and a status bit shows running.
// [R19] With auto start set, protocol events start the timer.
// [R20] Stage lasts reload plus one ticks; prescale period 2P+1 or 2P+2.
// [R21] Sleep bit stops the oscillator buffer at once, keeping all state.
// [R22] After clearing sleep, the bit reads one for 1024 clocks.
// [R23] Data writes push one byte; data reads pop the head byte.
// [R24] Pin stays active while any enabled flag remains set.
`timescale 1ns/1ns
module fifo_status_irq_timer #(
  parameter int DEPTH = 64,
  parameter int PRE_W = 12,
  parameter int CNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_frame_end,
  input wire logic rx_frame_end,
  input wire logic checksum_ready,
  input wire logic command_finished,
  input wire logic [7:0] fault_bits,
  input wire logic timer_auto_event,
  output logic [3:0] command_code,
  output logic osc_buffer_en,
  output logic irq
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_LEVEL = (PTR_W+1)'(DEPTH);
  localparam logic [10:0] EXIT_LAST = 11'(fifo_status_irq_timer_pkg::SLEEP_EXIT_CLKS - 1);
  localparam logic [PRE_W:0] PRE_ZERO = '0;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [5:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] view [0:15];
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  wire do_wr = aw_held_r && w_held_r && !bvalid_r;
  wire do_rd = s_axi_arvalid && !rvalid_r;
  wire wr_ok = awaddr_r[5:2] < 4'(fifo_status_irq_timer_pkg::REG_COUNT);
  wire rd_ok = s_axi_araddr[5:2] < 4'(fifo_status_irq_timer_pkg::REG_COUNT);
  wire [31:0] wd = merge(view[awaddr_r[5:2]], wdata_r, wstrb_r);
  wire wr_hit = do_wr && wr_ok;
  wire wr_fifo = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_FIFO_DATA && wstrb_r[0];
  wire wr_fill = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_FILL;
  wire wr_thr = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_THRESH;
  wire wr_en = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_IRQ_EN;
  wire wr_flag = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_IRQ_FLAG;
  wire wr_tmode = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_TMODE;
  wire wr_reload = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_RELOAD;
  wire wr_ctl = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_CONTROL;
  wire wr_cmd = wr_hit && awaddr_r == fifo_status_irq_timer_pkg::OFS_COMMAND;
  wire rd_fifo = do_rd && s_axi_araddr == fifo_status_irq_timer_pkg::OFS_FIFO_DATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bresp_r <= '0;
      rdata_r <= '0;
      rresp_r <= '0;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? fifo_status_irq_timer_pkg::RESP_OKAY
                         : fifo_status_irq_timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (do_rd) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_ok ? view[s_axi_araddr[5:2]] : '0;
        rresp_r <= rd_ok ? fifo_status_irq_timer_pkg::RESP_OKAY
                         : fifo_status_irq_timer_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Byte buffer
  // ----------------------------------------
  logic [7:0] mem_r [0:DEPTH-1];
  logic [PTR_W-1:0] wptr_r, rptr_r;
  logic [PTR_W:0] count_r;
  logic ovf_r;
  logic [5:0] thr_r;
  wire flush = wr_fill && wd[fifo_status_irq_timer_pkg::FLUSH_BIT];
  wire full = count_r == FULL_LEVEL;
  wire push = wr_fifo && !full;
  wire pop = rd_fifo && count_r != '0;
  wire [PTR_W:0] free_space = FULL_LEVEL - count_r;
  wire hi_warn = free_space <= (PTR_W+1)'(thr_r); // [R4]
  wire lo_warn = count_r <= (PTR_W+1)'(thr_r); // [R5]

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wptr_r] <= wd[7:0]; // [R23]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      ovf_r <= 1'b0;
      thr_r <= '0;
    end else begin
      if (wr_thr) begin
        thr_r <= wd[5:0];
      end
      if (flush) begin
        wptr_r <= '0; // [R1]
        rptr_r <= '0;
        count_r <= '0;
        ovf_r <= 1'b0; // [R3]
      end else begin
        wptr_r <= wptr_r + PTR_W'(push); // [R23]
        rptr_r <= rptr_r + PTR_W'(pop);
        count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop); // [R2]
        if (wr_fifo && full) begin
          ovf_r <= 1'b1; // [R3]
        end
      end
    end
  end

  // ----------------------------------------
  // Timer
  // ----------------------------------------
  logic [PRE_W-1:0] pre_reload_r;
  logic [CNT_W-1:0] cnt_reload_r, cnt_r;
  logic [PRE_W:0] pre_cnt_r;
  logic auto_r, autoreload_r, even_r, active_r, sleep_r;
  // Prescaler counts its load down to zero: period is load plus one.
  wire [PRE_W:0] pre_load = {pre_reload_r, even_r}; // [R20]
  wire tick = active_r && pre_cnt_r == PRE_ZERO && !sleep_r;
  wire kick = wr_ctl && wd[fifo_status_irq_timer_pkg::CTL_KICK];
  wire halt = wr_ctl && wd[fifo_status_irq_timer_pkg::CTL_HALT];
  wire start = kick || (auto_r && timer_auto_event); // [R19]
  wire timer_hit = tick && cnt_r == CNT_W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reload_r <= '0;
      cnt_reload_r <= '0;
      auto_r <= 1'b0;
      autoreload_r <= 1'b0;
      even_r <= 1'b0;
      active_r <= 1'b0;
      pre_cnt_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr_tmode) begin
        auto_r <= wd[fifo_status_irq_timer_pkg::TM_AUTO];
        autoreload_r <= wd[fifo_status_irq_timer_pkg::TM_RELOAD];
        even_r <= wd[fifo_status_irq_timer_pkg::TM_EVEN];
        pre_reload_r <= wd[fifo_status_irq_timer_pkg::TM_PRE_LSB +: PRE_W]; // [R14]
      end
      if (wr_reload) begin
        cnt_reload_r <= wd[CNT_W-1:0]; // [R15]
      end
      if (halt) begin
        active_r <= 1'b0; // [R18]
      end else if (start && !sleep_r) begin
        active_r <= 1'b1; // [R18]
        pre_cnt_r <= pre_load;
        cnt_r <= cnt_reload_r;
      end else if (tick) begin
        pre_cnt_r <= pre_load;
        if (cnt_r != '0) begin
          cnt_r <= cnt_r - CNT_W'(1); // [R8]
        end else if (autoreload_r) begin
          cnt_r <= cnt_reload_r; // [R16]
        end else begin
          active_r <= 1'b0; // [R16]
        end
      end else if (active_r && !sleep_r) begin
        pre_cnt_r <= pre_cnt_r - (PRE_W+1)'(1);
      end
    end
  end

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  logic [7:0] flags_r, irq_en_r;
  logic hi_prev_r, lo_prev_r, csum_prev_r, irq_r;
  logic [3:0] cmd_r;
  wire [7:0] fault_view = fault_bits | (8'(ovf_r) << fifo_status_irq_timer_pkg::FAULT_OVF);
  wire cmd_done = command_finished && cmd_r != fifo_status_irq_timer_pkg::CMD_IDLE;
  wire [7:0] hw_set = {csum_prev_r == 1'b0 && checksum_ready, // [R10]
                       |fault_view, // [R13]
                       lo_warn && !lo_prev_r, // [R12]
                       hi_warn && !hi_prev_r, // [R12]
                       cmd_done, // [R11]
                       rx_frame_end, // [R9]
                       tx_frame_end, // [R9]
                       timer_hit}; // [R8]
  wire flag_set_mode = wd[fifo_status_irq_timer_pkg::FLAG_SET_BIT];
  wire [7:0] sw_set = (wr_flag && flag_set_mode) ? wd[7:0] : 8'h00; // [R17]
  wire [7:0] sw_clr = (wr_flag && !flag_set_mode) ? wd[7:0] : 8'h00; // [R17]
  wire pending = |(flags_r & irq_en_r); // [R7]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= '0;
      irq_en_r <= '0;
      hi_prev_r <= 1'b0;
      lo_prev_r <= 1'b1;
      csum_prev_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      // A hardware event in the clearing cycle survives.
      flags_r <= (flags_r & ~sw_clr) | hw_set | sw_set;
      if (wr_en) begin
        irq_en_r <= wd[7:0];
      end
      hi_prev_r <= hi_warn;
      lo_prev_r <= lo_warn;
      csum_prev_r <= checksum_ready;
      irq_r <= pending; // [R6] [R24]
    end
  end
  assign irq = irq_r;

  // ----------------------------------------
  // Command field and soft sleep
  // ----------------------------------------
  logic exit_pend_r;
  logic [10:0] exit_cnt_r;
  wire [3:0] cmd_wr = wd[3:0];
  wire sleep_wr = wd[fifo_status_irq_timer_pkg::CMD_SLEEP];
  wire exit_done = exit_pend_r && exit_cnt_r == EXIT_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= fifo_status_irq_timer_pkg::CMD_IDLE;
      sleep_r <= 1'b0;
      exit_pend_r <= 1'b0;
      exit_cnt_r <= '0;
    end else begin
      if (wr_cmd && cmd_wr != fifo_status_irq_timer_pkg::CMD_KEEP) begin
        cmd_r <= cmd_wr;
      end else if (cmd_done) begin
        cmd_r <= fifo_status_irq_timer_pkg::CMD_IDLE; // [R11]
      end
      exit_cnt_r <= exit_pend_r ? exit_cnt_r + 11'd1 : 11'd0;
      if (wr_cmd && sleep_wr) begin
        sleep_r <= 1'b1; // [R21]
        exit_pend_r <= 1'b0;
      end else if (wr_cmd && sleep_r && !exit_pend_r) begin
        exit_pend_r <= 1'b1; // [R22]
      end else if (exit_done) begin
        sleep_r <= 1'b0; // [R22]
        exit_pend_r <= 1'b0;
      end
    end
  end
  assign command_code = cmd_r;
  // The oscillator buffer and the timer are gated; pins and state are left untouched.
  assign osc_buffer_en = !sleep_r; // [R21]

  // ----------------------------------------
  // Register views
  // ----------------------------------------
  assign view[0] = {24'h0, count_r == '0 ? 8'h00 : mem_r[rptr_r]};
  assign view[1] = {24'h0, 1'b0, count_r}; // [R2]
  assign view[2] = {26'h0, thr_r};
  assign view[3] = {28'h0, pending, active_r, hi_warn, lo_warn}; // [R7] [R18]
  assign view[4] = {24'h0, irq_en_r};
  assign view[5] = {24'h0, flags_r};
  assign view[6] = {12'h0, pre_reload_r, 5'h0, even_r, autoreload_r, auto_r};
  assign view[7] = {16'h0, cnt_reload_r};
  assign view[8] = {16'h0, cnt_r}; // [R15]
  assign view[9] = 32'h0000_0000;
  assign view[10] = {27'h0, sleep_r, cmd_r};
  assign view[11] = {24'h0, fault_view};
  assign view[12] = 32'h0000_0000;
  assign view[13] = 32'h0000_0000;
  assign view[14] = 32'h0000_0000;
  assign view[15] = 32'h0000_0000;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_exit_wait;
    exit_pend_r && !(wr_cmd && sleep_wr);
  endsequence

  a_flush_empties: assert property (flush |=> count_r == '0 && !ovf_r) // [R1]
    else $error("flush did not empty the buffer");
  a_fill_bound: assert property (count_r <= FULL_LEVEL) // [R2]
    else $error("fill count beyond capacity");
  a_ovf_sticky: assert property (ovf_r && !flush |=> ovf_r) // [R3]
    else $error("overflow cleared without flush");
  a_high_when_full: assert property (full && !flush |-> view[3][1]) // [R4]
    else $error("high warning missing when full");
  a_low_when_empty: assert property (count_r == '0 |-> view[3][0]) // [R5]
    else $error("low warning missing when empty");
  a_warn_flag: assert property ($rose(hi_warn) |=> flags_r[4]) // [R12]
    else $error("high warning flag not set");
  a_timer_flag: assert property (timer_hit |=> flags_r[0] && cnt_r == '0) // [R8]
    else $error("timer flag not set at zero");
  a_timer_reload: assert property (tick && cnt_r == '0 && autoreload_r && !halt && !start
    |=> cnt_r == $past(cnt_reload_r) && active_r) // [R16]
    else $error("timer did not reload");
  a_halt_stops: assert property (halt |=> !active_r ##1 (!active_r || $past(start))) // [R18]
    else $error("halt did not stop timer");
  a_irq_level: assert property (pending |=> irq) // [R24]
    else $error("interrupt pin not active");
  a_cmd_done: assert property (cmd_done && !wr_cmd |=> cmd_r == 4'h0 && flags_r[3]) // [R11]
    else $error("command done not flagged");
  a_sleep_exit: assert property ($fell(sleep_r) |-> $past(exit_cnt_r) == EXIT_LAST) // [R22]
    else $error("sleep left before exit delay");
  a_sleep_hold: assert property (s_exit_wait |-> sleep_r) // [R22]
    else $error("sleep bit dropped early");
endmodule : fifo_status_irq_timer

// File: tb/far_side_model.sv
// Model of the sequencer, transmitter, receiver and checksum logic beside the unit.
// Assumes it shares aclk with the unit; the bench calls its tasks.
`timescale 1ns/1ns
module far_side_model (
  input wire logic aclk,
  input wire logic [3:0] command_code,
  output logic tx_frame_end,
  output logic rx_frame_end,
  output logic checksum_ready,
  output logic command_finished,
  output logic [7:0] fault_bits,
  output logic timer_auto_event
);
  // ----------------------------------------
  // Command completion
  // ----------------------------------------
  int cmd_delay = 3;
  int wait_n = 0;
  initial begin
    tx_frame_end = 1'b0;
    rx_frame_end = 1'b0;
    checksum_ready = 1'b0;
    command_finished = 1'b0;
    fault_bits = 8'h00;
    timer_auto_event = 1'b0;
  end
  always @(posedge aclk) begin
    command_finished <= 1'b0;
    if (command_code !== 4'h0 && wait_n >= cmd_delay) begin
      command_finished <= 1'b1;
      wait_n <= 0;
    end else if (command_code !== 4'h0) begin
      wait_n <= wait_n + 1;
    end else begin
      wait_n <= 0;
    end
  end
  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  task automatic pulse(input int which);
    @(posedge aclk);
    case (which)
      0: tx_frame_end <= 1'b1;
      1: rx_frame_end <= 1'b1;
      default: timer_auto_event <= 1'b1;
    endcase
    @(posedge aclk);
    tx_frame_end <= 1'b0;
    rx_frame_end <= 1'b0;
    timer_auto_event <= 1'b0;
  endtask : pulse
  task automatic set_level(input logic csum, input logic [7:0] faults);
    @(posedge aclk);
    checksum_ready <= csum;
    fault_bits <= faults;
  endtask : set_level
endmodule : far_side_model

// File: tb/tb_top.sv
// Self-checking bench for the buffer, interrupt and timer unit.
// Assumes the package, unit and model are compiled first.
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam A_DATA = fifo_status_irq_timer_pkg::OFS_FIFO_DATA;
  localparam A_FILL = fifo_status_irq_timer_pkg::OFS_FILL;
  localparam A_STAT = fifo_status_irq_timer_pkg::OFS_STATUS;
  localparam A_EN = fifo_status_irq_timer_pkg::OFS_IRQ_EN;
  localparam A_FLAG = fifo_status_irq_timer_pkg::OFS_IRQ_FLAG;
  localparam A_MODE = fifo_status_irq_timer_pkg::OFS_TMODE;
  localparam A_CTRL = fifo_status_irq_timer_pkg::OFS_CONTROL;
  localparam A_CMD = fifo_status_irq_timer_pkg::OFS_COMMAND;
  localparam A_FLT = fifo_status_irq_timer_pkg::OFS_FAULT;
  localparam A_CNT = fifo_status_irq_timer_pkg::OFS_COUNT;
  localparam R_ERR = fifo_status_irq_timer_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc_buffer_en, irq;
  logic [1:0] bresp, rresp, last_rresp;
  logic [31:0] rdata;
  logic tx_frame_end, rx_frame_end, checksum_ready, command_finished, timer_auto_event;
  logic [7:0] fault_bits;
  logic [3:0] command_code;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  fifo_status_irq_timer i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_frame_end(tx_frame_end), .rx_frame_end(rx_frame_end),
    .checksum_ready(checksum_ready), .command_finished(command_finished),
    .fault_bits(fault_bits), .timer_auto_event(timer_auto_event),
    .command_code(command_code), .osc_buffer_en(osc_buffer_en), .irq(irq)
  );
  far_side_model i_far (
    .aclk(aclk), .command_code(command_code), .tx_frame_end(tx_frame_end),
    .rx_frame_end(rx_frame_end), .checksum_ready(checksum_ready),
    .command_finished(command_finished), .fault_bits(fault_bits),
    .timer_auto_event(timer_auto_event)
  );
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk({bresp, n < 50}, {(a >= 6'h30) ? R_ERR : 2'h0, 1'b1});
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    last_rresp = rresp;
    rready <= 1'b0;
    chk(n < 50, 1'b1);
  endtask : rd
  task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask : rc
  task automatic wait_irq(input int lim);
    for (int m = 0; m < lim && irq !== 1'b1; m++) @(posedge aclk);
  endtask : wait_irq
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fifo;
    rc(A_STAT, 32'h0000_0004, 32'h0000_0000);
    wr(fifo_status_irq_timer_pkg::OFS_THRESH, 32'h0000_0004);
    wr(A_FILL, 32'h0000_0080);
    for (int i = 0; i < 5; i++) wr(A_DATA, 32'h0000_00A0 + i);
    rc(A_FILL, 32'h0000_007F, 32'h0000_0005);
    rc(A_STAT, 32'h0000_0001, 32'h0000_0000);
    rc(A_DATA, 32'h0000_00FF, 32'h0000_00A0);
    rc(A_STAT, 32'h0000_0001, 32'h0000_0001);
    for (int i = 4; i < 59; i++) wr(A_DATA, 32'h0000_0011);
    rc(A_STAT, 32'h0000_0002, 32'h0000_0000);
    wr(A_DATA, 32'h0000_0011);
    rc(A_STAT, 32'h0000_0002, 32'h0000_0002);
    for (int i = 60; i < 65; i++) wr(A_DATA, 32'h0000_0011);
    rc(A_FILL, 32'h0000_007F, 32'h0000_0040);
    rc(A_FLT, 32'h0000_0010, 32'h0000_0010);
    rc(A_DATA, 32'h0000_00FF, 32'h0000_00A1);
    rc(A_FLT, 32'h0000_0010, 32'h0000_0010);
    wr(A_FILL, 32'h0000_0080);
    rc(A_FILL, 32'h0000_007F, 32'h0000_0000);
    rc(A_FLT, 32'h0000_0010, 32'h0000_0000);
  endtask : t_fifo
  task automatic t_irq;
    wr(A_FLAG, 32'h0000_00FF);
    wr(A_EN, 32'h0000_0010);
    for (int i = 0; i < 60; i++) wr(A_DATA, 32'h0000_0022);
    rc(A_FLAG, 32'h0000_00FF, 32'h0000_0010);
    chk(irq, 1'b1);
    rc(A_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(A_FLAG, 32'h0000_0010);
    rc(A_STAT, 32'h0000_0008, 32'h0000_0000);
    chk(irq, 1'b0);
    wr(A_EN, 32'h0000_0020);
    wr(A_FILL, 32'h0000_0080);
    rc(A_FLAG, 32'h0000_00FF, 32'h0000_0020);
    chk(irq, 1'b1);
    wr(A_FLAG, 32'h0000_0020);
    wr(A_EN, 32'h0000_0000);
    chk(irq, 1'b0);
  endtask : t_irq
  task automatic t_events;
    logic [31:0] ev [4];
    ev = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0080, 32'h0000_0040};
    for (int k = 0; k < 4; k++) begin
      wr(A_FLAG, 32'h0000_00FF);
      if (k < 2) i_far.pulse(k);
      else i_far.set_level(k == 2, {7'h00, k == 3});
      rc(A_FLAG, 32'h0000_00FF, ev[k]);
    end
    wr(A_FLAG, 32'h0000_0040);
    rc(A_FLAG, 32'h0000_0040, 32'h0000_0040);
    rc(A_FLT, 32'h0000_000F, 32'h0000_0001);
    i_far.set_level(1'b0, 8'h00);
    wr(A_FLAG, 32'h0000_00FF);
    for (int j = 0; j < 2; j++) begin
      i_far.cmd_delay = j * 20 + 2;
      wr(A_CMD, 32'h0000_0004);
      chk(command_code, 4'h4);
      for (int m = 0; m < 100 && command_code !== 4'h0; m++) @(posedge aclk);
      chk(command_code, 4'h0);
      rc(A_FLAG, 32'h0000_0008, 32'h0000_0008);
      wr(A_FLAG, 32'h0000_0008);
    end
  endtask : t_events
  task automatic t_timer;
    int n;
    logic [31:0] d1, d2;
    wr(A_EN, 32'h0000_0001);
    wr(fifo_status_irq_timer_pkg::OFS_RELOAD, 32'h0000_0004);
    for (int e = 0; e < 2; e++) begin
      wr(A_MODE, 32'h0000_0200 | (e << 2));
      wr(A_CTRL, 32'h0000_0001);
      n = cyc;
      rc(A_STAT, 32'h0000_0004, 32'h0000_0004);
      wait_irq(200);
      n = cyc - n;
      chk(n >= (5 + e) * 4 - 1 && n <= (5 + e) * 4 + 3, 1'b1);
      repeat (12) @(posedge aclk);
      rc(A_STAT, 32'h0000_0004, 32'h0000_0000);
      rc(A_CNT, 32'h0000_FFFF, 32'h0000_0000);
      wr(A_FLAG, 32'h0000_0001);
    end
    wr(A_MODE, 32'h0000_0202);
    wr(A_CTRL, 32'h0000_0001);
    wait_irq(200);
    wr(A_FLAG, 32'h0000_0001);
    rc(A_STAT, 32'h0000_0004, 32'h0000_0004);
    wait_irq(40);
    chk(irq, 1'b1);
    wr(A_CTRL, 32'h0000_0002);
    rc(A_STAT, 32'h0000_0004, 32'h0000_0000);
    wr(A_FLAG, 32'h0000_0001);
    wr(A_FLAG, 32'h8000_0001);
    rc(A_FLAG, 32'h0000_0001, 32'h0000_0001);
    wr(A_FLAG, 32'h0000_0001);
    rc(A_FLAG, 32'h0000_0001, 32'h0000_0000);
    wr(A_MODE, 32'h000F_FF01);
    rc(A_MODE, 32'h000F_FF07, 32'h000F_FF01);
    wr(fifo_status_irq_timer_pkg::OFS_RELOAD, 32'h0000_FFFF);
    wr(A_MODE, 32'h0000_0001);
    i_far.pulse(2);
    rc(A_STAT, 32'h0000_0004, 32'h0000_0004);
    rd(A_CNT, d1);
    rd(A_CNT, d2);
    chk(d2 < d1 && d1 <= 32'h0000_FFFF, 1'b1);
    wr(A_CTRL, 32'h0000_0002);
    wr(A_EN, 32'h0000_0000);
  endtask : t_timer
  task automatic t_sleep;
    logic [31:0] d;
    int t0;
    wr(A_FILL, 32'h0000_0080);
    wr(A_DATA, 32'h0000_0033);
    wr(A_CMD, 32'h0000_0010);
    rc(A_CMD, 32'h0000_0010, 32'h0000_0010);
    chk(osc_buffer_en, 1'b0);
    rc(A_FILL, 32'h0000_007F, 32'h0000_0001);
    wr(A_CMD, 32'h0000_0007);
    t0 = cyc;
    d = 32'h0000_0010;
    for (int m = 0; m < 600 && d[4] !== 1'b0; m++) rd(A_CMD, d);
    chk(cyc - t0 >= 1016 && cyc - t0 <= 1034, 1'b1);
    chk(osc_buffer_en, 1'b1);
    wr(6'h30, 32'hFFFF_FFFF);
    rd(6'h3C, d);
    chk({d, last_rresp}, {32'h0000_0000, R_ERR});
  endtask : t_sleep
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic summarize;
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({command_code, osc_buffer_en, irq}, 6'b0000_10);
    t_fifo();
    t_irq();
    t_events();
    t_timer();
    t_sleep();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    summarize();
  end
endmodule : tb_top
